//--- pkg/iba_pkg.sv
// package: constants, register map and carrier types of the bid arbiter
package iba_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned SAMPLE_NS    = 26_040;
  localparam int unsigned SAMPLE_CYC   = SAMPLE_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [8:0]  SAMPLE_LAST  = 9'(SAMPLE_CYC - 1);
  localparam logic [5:0]  WD_LAST      = 6'h3F;
  localparam logic [1:0]  CS_GAP       = 2'h2;
  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_MASK     = 12'h004;
  localparam logic [11:0] OFS_RXMODE   = 12'h008;
  localparam logic [11:0] OFS_PINCHG   = 12'h00C;
  localparam logic [11:0] OFS_WINNER   = 12'h010;
  localparam logic [11:0] OFS_VECTOR   = 12'h014;
  localparam logic [11:0] OFS_BUSLAT   = 12'h018;
  localparam logic [11:0] OFS_GLOBAL   = 12'h01C;
  localparam logic [11:0] OFS_EVSTAT   = 12'h020;
  localparam logic [11:0] OFS_EVMASK   = 12'h024;
  localparam logic [11:0] OFS_PRIO     = 12'h028;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int unsigned CTRL_DIV_BIT = 0;
  localparam int unsigned CTRL_MOD_BIT = 1;
  localparam int unsigned CTRL_TH_LSB  = 8;
  localparam int unsigned MODE_WD_BIT  = 7;
  localparam int unsigned PIN_LVL_LSB  = 8;
  localparam int unsigned GLB_CNT_LSB  = 8;
  // --------------------------------------------------------------
  // reset values and bid constants
  // --------------------------------------------------------------
  localparam logic [7:0]  RST_THRESH   = 8'h00;
  localparam logic [17:0] RST_MASK     = 18'h0_0000;
  localparam logic [7:0]  RST_VECTOR   = 8'h0F;
  localparam logic [7:0]  RST_PRIO     = 8'h00;
  localparam logic [7:0]  NO_BID       = 8'hFF;
  localparam logic [1:0]  TYPE_RX      = 2'h3;
  localparam logic [1:0]  TYPE_TX      = 2'h2;
  localparam logic [2:0]  TYPE_BRK     = 3'h4;
  localparam logic [2:0]  TYPE_CHG     = 3'h1;
  localparam logic [3:0]  TYPE_CT      = 4'hD;
  localparam logic [1:0]  CT_CHAN_AB   = 2'h1;
  localparam logic [1:0]  CT_CHAN_CD   = 2'h3;
  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } iba_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } iba_apb_rsp_t;

  typedef struct packed {
    logic [3:0][2:0] rxFill;
    logic [3:0]      rxErr;
    logic [3:0][2:0] txAvail;
    logic [3:0]      txFull;
    logic [3:0]      brkPend;
    logic [1:0]      ctPend;
    logic [3:0]      bitClkTick;
    logic [3:0]      charLoad;
    logic [3:0]      rxRead;
  } iba_src_t;
endpackage

//--- src/iba_arbiter.sv
// interrupt bid arbiter with receiver watchdogs and pin change detectors
`timescale 1ns/1ps
module iba_arbiter
  import iba_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire iba_apb_req_t apbReq,
  output iba_apb_rsp_t      apbRsp,
  input  wire iba_src_t     src,
  input  wire logic [3:0]   multiusePinZero,
  input  wire logic [3:0]   multiusePinOne,
  input  wire logic         chipSelect_n,
  input  wire logic         interruptAck_n,
  output logic              interruptRequestNOut,
  output logic              interruptRequestNOe,
  output logic [7:0]        ackVector,
  output logic              ackValid,
  output logic              eventIrq
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      pinS1;
    logic [7:0]      pinS2;
    logic            csS1;
    logic            csS2;
    logic            ackS1;
    logic            ackS2;
    logic            ackPrev;
    logic [8:0]      sampCnt;
    logic [7:0]      pinSample;
    logic [7:0]      lastRead;
    logic [7:0]      pinChg;
    logic [3:0][5:0] wdCnt;
    logic            divEn;
    logic            vecMod;
    logic [7:0]      threshold;
    logic [17:0]     srcMask;
    logic [3:0]      wdEnable;
    logic [7:0]      vecBase;
    logic [7:0]      prio;
    logic [7:0]      evStat;
    logic [7:0]      evMask;
    logic            evalPh;
    logic [7:0]      busLatch;
    logic [7:0]      winner;
    logic [1:0]      csGap;
    logic            interrupt_request_n;
    logic [7:0]      ackData;
    logic            ackPulse;
    logic [31:0]     rdata;
    logic            rdErr;
  } iba_state_t;

  iba_state_t st_r;
  iba_state_t st_nxt;

  // --------------------------------------------------------------
  // bid formation and arbitration
  // --------------------------------------------------------------
  logic [17:0][7:0] bid;
  logic [17:0]      bidLive;
  logic [7:0]       busMax;
  logic [7:0]       winVal;

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // receive fill: count, error, type, channel
      bid[c]      = {src.rxFill[c], src.rxErr[c], TYPE_RX, 2'(c)};
      // empty receive queue makes no bid
      bidLive[c]  = (src.rxFill[c] != 3'h0);
      bid[c+4]    = {st_r.prio[2:0], TYPE_BRK, 2'(c)};
      bidLive[c+4] = src.brkPend[c];
      // transmit top bit is always zero
      bid[c+8]    = {1'b0, src.txAvail[c], TYPE_TX, 2'(c)};
      bidLive[c+8] = ~src.txFull[c];
      bid[c+12]   = {st_r.prio[5:3], TYPE_CHG, 2'(c)};
      bidLive[c+12] = |{st_r.pinChg[c+4], st_r.pinChg[c]};
    end
    bid[16]     = {st_r.prio[7:6], TYPE_CT, CT_CHAN_AB};
    bidLive[16] = src.ctPend[0];
    bid[17]     = {st_r.prio[7:6], TYPE_CT, CT_CHAN_CD};
    bidLive[17] = src.ctPend[1];
  end

  // the shared bus is modelled as the largest live bid: channel bits make
  // every bid unique, so a single winner is left driving it
  always_comb begin
    busMax = 8'h00;
    for (int s = 0; s < 18; s++) begin
      // masked sources stay off the bus
      if (bidLive[s] && st_r.srcMask[s] && bid[s] > busMax) begin
        busMax = bid[s];
      end
    end
  end

  // latched bus is active low; FFh means no bidder
  assign winVal = ~st_r.busLatch;

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        wrDone;
  logic        rdDone;
  logic        mapped;
  logic        ackEdge;
  logic        evalNow;
  logic [7:0]  pinLevels;

  assign setup   = apbReq.psel & ~apbReq.penable;
  assign access  = apbReq.psel & apbReq.penable;
  assign wrDone  = access & apbReq.pwrite & ~st_r.rdErr;
  assign rdDone  = access & ~apbReq.pwrite & ~st_r.rdErr;
  assign ackEdge = st_r.ackPrev & ~st_r.ackS2;
  // one evaluation per crystal clock, or every second when divided, none on an acknowledge edge
  assign evalNow = (~st_r.divEn | st_r.evalPh) & ~ackEdge;
  assign pinLevels = {multiusePinOne, multiusePinZero};

  always_comb begin
    mapped = 1'b1;
    unique case (apbReq.paddr)
      OFS_CTRL, OFS_MASK, OFS_RXMODE, OFS_PINCHG, OFS_WINNER,
      OFS_VECTOR, OFS_BUSLAT, OFS_GLOBAL, OFS_EVSTAT, OFS_EVMASK,
      OFS_PRIO: mapped = 1'b1;
      default:  mapped = 1'b0;
    endcase
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic [7:0] setEv;
    logic [7:0] clrEv;
    logic [7:0] chgSet;
    setEv  = 8'h00;
    clrEv  = 8'h00;
    chgSet = 8'h00;
    st_nxt = st_r;

    // pins and strobes from outside pass two flops first
    st_nxt.pinS1   = pinLevels;
    st_nxt.pinS2   = st_r.pinS1;
    st_nxt.csS1    = chipSelect_n;
    st_nxt.csS2    = st_r.csS1;
    st_nxt.ackS1   = interruptAck_n;
    st_nxt.ackS2   = st_r.ackS1;
    st_nxt.ackPrev = st_r.ackS2;

    // periodic sampling; pin direction plays no part
    if (st_r.sampCnt == SAMPLE_LAST) begin
      st_nxt.sampCnt   = 9'h000;
      st_nxt.pinSample = st_r.pinS2;
      chgSet           = st_r.pinS2 ^ st_r.lastRead;
    end else begin
      st_nxt.sampCnt = st_r.sampCnt + 9'h001;
    end
    // a read clears the detectors, a fresh change still wins
    if (rdDone && apbReq.paddr == OFS_PINCHG) begin
      st_nxt.lastRead = st_r.pinSample;
      st_nxt.pinChg   = chgSet;
    end else begin
      st_nxt.pinChg = st_r.pinChg | chgSet;
    end
    for (int c = 0; c < 4; c++) begin
      setEv[c+4] = chgSet[c] | chgSet[c+4];
    end

    // receiver watchdogs
    for (int c = 0; c < 4; c++) begin
      if (src.charLoad[c] || src.rxRead[c]) begin
        st_nxt.wdCnt[c] = 6'h00;
      end else if (src.bitClkTick[c]) begin
        st_nxt.wdCnt[c] = st_r.wdCnt[c] + 6'h01;
        // 64th bit clock since restart
        if (st_r.wdCnt[c] == WD_LAST) begin
          setEv[c] = st_r.wdEnable[c];
        end
      end
    end

    // evaluation period and bus latch
    st_nxt.evalPh = st_r.divEn ? ~st_r.evalPh : 1'b0;
    if (evalNow) begin
      st_nxt.busLatch = ~busMax;
    end

    // acknowledge: capture the last latched result, skip this evaluation
    st_nxt.ackPulse = ackEdge;
    if (ackEdge) begin
      st_nxt.winner  = winVal;
      st_nxt.ackData = st_r.vecMod ? {st_r.vecBase[7:5], winVal[4:0]}
                                   : st_r.vecBase;
    end

    // chip select gap: request held off during an access and for two
    // periods after it, so a short gap does not raise a stray request
    if (!st_r.csS2) begin
      st_nxt.csGap = 2'h0;
    end else if (evalNow && st_r.csGap != CS_GAP) begin
      st_nxt.csGap = st_r.csGap + 2'h1;
    end

    // request follows the comparison as a level
    if (evalNow) begin
      st_nxt.interrupt_request_n = ~((~busMax == NO_BID ? 1'b0 : busMax > st_r.threshold)
                      & st_r.csS2 & (st_r.csGap == CS_GAP));
    end

    // register reads are prepared in the setup cycle
    if (setup) begin
      st_nxt.rdErr = ~mapped;
      st_nxt.rdata = 32'h0000_0000;
      unique case (apbReq.paddr)
        OFS_CTRL: begin
          st_nxt.rdata[CTRL_DIV_BIT] = st_r.divEn;
          st_nxt.rdata[CTRL_MOD_BIT] = st_r.vecMod;
          st_nxt.rdata[CTRL_TH_LSB +: 8] = st_r.threshold;
        end
        OFS_MASK:   st_nxt.rdata[17:0] = st_r.srcMask;
        OFS_RXMODE: begin
          for (int c = 0; c < 4; c++) begin
            st_nxt.rdata[8*c + MODE_WD_BIT] = st_r.wdEnable[c];
          end
        end
        OFS_PINCHG: begin
          st_nxt.rdata[7:0] = st_r.pinChg;
          st_nxt.rdata[PIN_LVL_LSB +: 8] = st_r.pinSample;
        end
        OFS_WINNER: st_nxt.rdata[7:0] = st_r.winner;
        OFS_VECTOR: st_nxt.rdata[7:0] = st_r.vecBase;
        OFS_BUSLAT: st_nxt.rdata[7:0] = st_r.busLatch;
        OFS_GLOBAL: begin
          // global channel and byte count follow the winner
          st_nxt.rdata[1:0] = st_r.winner[1:0];
          st_nxt.rdata[GLB_CNT_LSB +: 3] = st_r.winner[7:5];
        end
        OFS_EVSTAT: st_nxt.rdata[7:0] = st_r.evStat;
        OFS_EVMASK: st_nxt.rdata[7:0] = st_r.evMask;
        OFS_PRIO:   st_nxt.rdata[7:0] = st_r.prio;
        default:    st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // register writes take effect at the completing edge
    if (wrDone) begin
      unique case (apbReq.paddr)
        OFS_CTRL: begin
          st_nxt.divEn     = apbReq.pwdata[CTRL_DIV_BIT];
          st_nxt.vecMod    = apbReq.pwdata[CTRL_MOD_BIT];
          st_nxt.threshold = apbReq.pwdata[CTRL_TH_LSB +: 8];
        end
        OFS_MASK: st_nxt.srcMask = apbReq.pwdata[17:0];
        OFS_RXMODE: begin
          for (int c = 0; c < 4; c++) begin
            st_nxt.wdEnable[c] = apbReq.pwdata[8*c + MODE_WD_BIT];
          end
        end
        // a write here updates the winner from the latched bus
        OFS_WINNER: st_nxt.winner = winVal;
        OFS_VECTOR: st_nxt.vecBase = apbReq.pwdata[7:0];
        OFS_EVSTAT: clrEv = apbReq.pwdata[7:0];
        OFS_EVMASK: st_nxt.evMask = apbReq.pwdata[7:0];
        OFS_PRIO:   st_nxt.prio = apbReq.pwdata[7:0];
        default:    st_nxt.prio = st_r.prio;
      endcase
    end

    // sticky events: a set in the clearing cycle survives
    st_nxt.evStat = (st_r.evStat & ~clrEv) | setEv;
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r           <= '0;
      st_r.csS1      <= 1'b1;
      st_r.csS2      <= 1'b1;
      st_r.ackS1     <= 1'b1;
      st_r.ackS2     <= 1'b1;
      st_r.ackPrev   <= 1'b1;
      st_r.threshold <= RST_THRESH;
      st_r.srcMask   <= RST_MASK;
      st_r.vecBase   <= RST_VECTOR;
      st_r.prio      <= RST_PRIO;
      st_r.busLatch  <= NO_BID;
      st_r.csGap     <= CS_GAP;
      st_r.interrupt_request_n      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // open drain: only ever pulls low, released otherwise
  assign interruptRequestNOut = 1'b0;
  assign interruptRequestNOe  = ~st_r.interrupt_request_n;
  assign ackVector            = st_r.ackData;
  assign ackValid             = st_r.ackPulse;
  assign eventIrq             = |(st_r.evStat & st_r.evMask);
  assign apbRsp.prdata        = st_r.rdata;
  assign apbRsp.pready        = access;
  assign apbRsp.pslverr       = access & st_r.rdErr;
endmodule

//--- testbench/iba_arbiter_asserts.sv
// checker: port-level properties of the bid arbiter
`timescale 1ns/1ps
module iba_arbiter_asserts
  import iba_pkg::*;
(
  input wire logic         mclk,
  input wire logic         arst_n,
  input wire iba_apb_req_t apbReq,
  input wire iba_apb_rsp_t apbRsp,
  input wire iba_src_t     src,
  input wire logic [3:0]   multiusePinZero,
  input wire logic [3:0]   multiusePinOne,
  input wire logic         chipSelect_n,
  input wire logic         interruptAck_n,
  input wire logic         interruptRequestNOut,
  input wire logic         interruptRequestNOe,
  input wire logic [7:0]   ackVector,
  input wire logic         ackValid,
  input wire logic         eventIrq
);
  // ------------------------------------------------------------
  // shadow of the writable fields the properties depend on
  // ------------------------------------------------------------
  logic [17:0] maskR;
  logic [7:0]  threshR;
  logic [7:0]  evMaskR;
  logic        wrHit;
  assign wrHit = apbReq.psel & apbReq.penable & apbReq.pwrite;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      maskR <= RST_MASK;
      threshR <= RST_THRESH;
      evMaskR <= 8'h00;
    end else if (wrHit) begin
      if (apbReq.paddr == OFS_MASK) maskR <= apbReq.pwdata[17:0];
      if (apbReq.paddr == OFS_CTRL) threshR <= apbReq.pwdata[15:8];
      if (apbReq.paddr == OFS_EVMASK) evMaskR <= apbReq.pwdata[7:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_pin_drive_low: assert property (interruptRequestNOut == 1'b0)
    else $error("request pin driven high");
  a_ack_one_pulse: assert property (ackValid |=> !ackValid)
    else $error("ack strobe longer than one cycle");
  a_ack_follows_fall: assert property (
    $fell(interruptAck_n) |-> ##[2:6] ackValid)
    else $error("no vector after acknowledge");
  a_vector_on_ack: assert property ($changed(ackVector) |-> ackValid)
    else $error("vector changed without acknowledge");
  a_cs_hold_off: assert property (
    (!chipSelect_n) [*6] |-> !interruptRequestNOe)
    else $error("request during chip select access");
  a_mask_no_bid: assert property (
    (maskR == RST_MASK) [*4] |-> !interruptRequestNOe)
    else $error("request with every source masked");
  a_thresh_top: assert property (
    (threshR == 8'hFF) [*4] |-> !interruptRequestNOe)
    else $error("request above maximum threshold");
  a_event_masked: assert property (
    (evMaskR == 8'h00) [*2] |-> !eventIrq)
    else $error("event interrupt while all masked");
  c_ack: cover property (ackValid);
  c_req: cover property ($rose(interruptRequestNOe));
  c_evt: cover property ($rose(eventIrq));
endmodule

bind iba_arbiter iba_arbiter_asserts i_iba_arbiter_asserts (
  .mclk(mclk), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp),
  .src(src), .multiusePinZero(multiusePinZero),
  .multiusePinOne(multiusePinOne), .chipSelect_n(chipSelect_n),
  .interruptAck_n(interruptAck_n),
  .interruptRequestNOut(interruptRequestNOut),
  .interruptRequestNOe(interruptRequestNOe), .ackVector(ackVector),
  .ackValid(ackValid), .eventIrq(eventIrq));

//--- testbench/iba_host_model.sv
// host model: acknowledge cycles and the pulled-up request line
`timescale 1ns/1ps
module iba_host_model (
  input  wire logic       mclk,
  input  wire logic       irqOut,
  input  wire logic       irqOe,
  input  wire logic       ackValid,
  input  wire logic [7:0] ackVector,
  output logic            ackReq_n,
  output logic            irqLine
);
  // open drain: a released line floats up to the pull-up
  assign irqLine = irqOe ? irqOut : 1'b1;
  initial ackReq_n = 1'b1;
  // ack held until the strobe; two high cycles re-arm the detector
  task automatic ack(output logic [7:0] vec);
    @(posedge mclk);
    ackReq_n <= 1'b0;
    do @(posedge mclk); while (ackValid !== 1'b1);
    vec = ackVector;
    ackReq_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
endmodule

//--- testbench/test_interrupt_bid_arbiter.sv
// testbench: self-checking scenarios for the bid arbiter
`timescale 1ns/1ps
module test_interrupt_bid_arbiter
  import iba_pkg::*;
;
  logic         mclk = 1'b0;
  logic         arst_n, csN, ackN, noe, nout, ackV, evIrq, irqLine;
  logic         lastErr;
  iba_apb_req_t req;
  iba_apb_rsp_t rsp;
  iba_src_t     src;
  logic [3:0]   pin0, pin1;
  logic [7:0]   ackVec, v;
  logic [31:0]  q;
  int           err_count, check_count;
  always #50 mclk = ~mclk;
  iba_arbiter i_iba_arbiter (.mclk(mclk), .arst_n(arst_n),
    .apbReq(req), .apbRsp(rsp), .src(src), .multiusePinZero(pin0),
    .multiusePinOne(pin1), .chipSelect_n(csN), .interruptAck_n(ackN),
    .interruptRequestNOut(nout), .interruptRequestNOe(noe),
    .ackVector(ackVec), .ackValid(ackV), .eventIrq(evIrq));
  iba_host_model i_iba_host_model (.mclk(mclk), .irqOut(nout),
    .irqOe(noe), .ackValid(ackV), .ackVector(ackVec),
    .ackReq_n(ackN), .irqLine(irqLine));
  // ------------------------------------------------------------
  // bus and comparison helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    lastErr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [17:0] d);
    apb(1'b1, a, {14'h0000, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, {16'h0000, e});
  endtask
  // request line needs sync and evaluation edges to follow a change
  task automatic irq(input logic e);
    repeat (6) @(posedge mclk);
    chk(32'(irqLine), 32'(e));
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      src.bitClkTick <= 4'h3;
      @(posedge mclk);
      src.bitClkTick <= 4'h0;
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_MASK, 16'h0000);
    rd(OFS_VECTOR, 16'h000F);
    rd(OFS_BUSLAT, 16'h00FF);
    rd(OFS_WINNER, 16'h0000);
    rd(12'h100, 16'h0000);
    chk(32'(lastErr), 32'h0000_0001);
  endtask
  task automatic t_arb;
    src.rxFill[2] <= 3'h3;
    src.txAvail[1] <= 3'h7;
    wr(OFS_MASK, 18'h0_0204);
    rd(OFS_BUSLAT, 16'h0086);
    irq(1'b0);
    wr(OFS_CTRL, 18'h0_7900);
    irq(1'b1);
    wr(OFS_CTRL, 18'h0_7800);
    irq(1'b0);
    // no bid can exceed the top threshold
    wr(OFS_CTRL, 18'h0_FF00);
    irq(1'b1);
    wr(OFS_CTRL, 18'h0_0000);
    src.txFull[1] <= 1'b1;
    rd(OFS_BUSLAT, 16'h0091);
    src.txFull[1] <= 1'b0;
    wr(OFS_MASK, 18'h0_0004);
    rd(OFS_BUSLAT, 16'h0091);
    src.rxFill[2] <= 3'h0;
    rd(OFS_BUSLAT, 16'h00FF);
    irq(1'b1);
    src.rxFill[2] <= 3'h3;
    wr(OFS_MASK, 18'h0_0204);
  endtask
  task automatic t_ack;
    i_iba_host_model.ack(v);
    chk(32'(v), 32'h0000_000F);
    rd(OFS_WINNER, 16'h0079);
    rd(OFS_GLOBAL, 16'h0301);
    wr(OFS_VECTOR, 18'h0_00A0);
    wr(OFS_CTRL, 18'h0_0002);
    i_iba_host_model.ack(v);
    chk(32'(v), 32'h0000_00B9);
    wr(OFS_CTRL, 18'h0_0000);
  endtask
  task automatic t_cs;
    irq(1'b0);
    csN <= 1'b0;
    irq(1'b1);
    csN <= 1'b1;
    irq(1'b0);
  endtask
  // divide-by-two evaluation with programmed priorities: counter/timer bids beat the break bid
  task automatic t_prog;
    wr(OFS_CTRL, 18'h0_0001);
    src.brkPend[0] <= 1'b1;
    src.ctPend <= 2'h2;
    wr(OFS_PRIO, 18'h0_00C7);
    wr(OFS_MASK, 18'h3_0010);
    // divided evaluation latches only on every second edge
    repeat (2) @(posedge mclk);
    rd(OFS_BUSLAT, 16'h0008);
    wr(OFS_WINNER, 18'h0_0000);
    rd(OFS_WINNER, 16'h00F7);
    src.ctPend <= 2'h1;
    repeat (2) @(posedge mclk);
    rd(OFS_BUSLAT, 16'h000A);
    src.ctPend <= 2'h0;
    repeat (2) @(posedge mclk);
    rd(OFS_BUSLAT, 16'h000F);
    src.brkPend[0] <= 1'b0;
    wr(OFS_CTRL, 18'h0_0000);
  endtask
  task automatic t_wdog;
    wr(OFS_RXMODE, 18'h0_0080);
    wr(OFS_EVMASK, 18'h0_00FF);
    // restarts are one-cycle pulses; 80 ticks unbroken would time out
    tick(40);
    src.charLoad[0] <= 1'b1;
    @(posedge mclk);
    src.charLoad[0] <= 1'b0;
    tick(40);
    src.rxRead[0] <= 1'b1;
    @(posedge mclk);
    src.rxRead[0] <= 1'b0;
    tick(63);
    rd(OFS_EVSTAT, 16'h0000);
    tick(1);
    rd(OFS_EVSTAT, 16'h0001);
    chk(32'(evIrq), 32'h0000_0001);
    wr(OFS_EVSTAT, 18'h0_0001);
    // the clear lands at the completing edge, look one edge later
    @(posedge mclk);
    chk(32'(evIrq), 32'h0000_0000);
  endtask
  task automatic t_pin;
    wr(OFS_PRIO, 18'h0_0038);
    wr(OFS_MASK, 18'h0_4000);
    pin1[2] <= 1'b1;
    repeat (300) @(posedge mclk);
    rd(OFS_BUSLAT, 16'h0019);
    rd(OFS_EVSTAT, 16'h0040);
    rd(OFS_PINCHG, 16'h4040);
    rd(OFS_PINCHG, 16'h4000);
    rd(OFS_BUSLAT, 16'h00FF);
  endtask
  initial begin
    #5_000_000;
    err_count++;
    finish_test();
  end
  initial begin
    arst_n = 1'b0;
    req = '0;
    src = '0;
    pin0 = 4'h0;
    pin1 = 4'h0;
    csN = 1'b1;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_arb();
    t_ack();
    t_cs();
    t_prog();
    t_wdog();
    t_pin();
    finish_test();
  end
endmodule
